// ### pct_throttle.sv
// Purpose: processor clock throttle with control/status register
// Assumes: register strobes synchronous to the pci clock, one cycle each
// Notes: thermal duty field is write once until reset
`timescale 1ns/1ps
module pct_throttle
	import pct_pkg::*;
#(
	parameter int OVERRIDE_CYCLES = PCT_OVERRIDE_CYCLES
)
(
	// clock and reset
	input wire logic pci_bus_clock,
	input wire logic reset_n,
	// register port
	input wire pct_bus_t bus,
	output logic [31:0] rdata_q,
	// system state and pins
	input wire logic cpu_in_c0,
	input wire logic thermal_alert_in_n,
	output logic stop_clock_out_n
);
	// --------------------------------------------------------------
	// reset release
	// --------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge pci_bus_clock or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// --------------------------------------------------------------
	// control register
	// --------------------------------------------------------------
	logic force_q, force_d;
	logic hw_throttle_enable_q, hw_throttle_enable_d;
	logic [2:0] hw_throttle_duty_code_q, hw_throttle_duty_code_d;
	logic [2:0] thermal_duty_code_q, thermal_duty_code_d;
	logic tduty_locked_q, tduty_locked_d;
	logic ctrl_wr, ctrl_rd, active;
	logic [31:0] rdata_d;

	assign ctrl_wr = bus.wr && (bus.addr == PCT_CTRL_OFFSET);
	assign ctrl_rd = bus.rd && (bus.addr == PCT_CTRL_OFFSET);
	assign force_d = ctrl_wr ? bus.wdata[PCT_FORCE_BIT] : force_q;
	assign hw_throttle_enable_d = ctrl_wr ? bus.wdata[PCT_HWEN_BIT] : hw_throttle_enable_q;
	assign hw_throttle_duty_code_d = ctrl_wr ? bus.wdata[PCT_HDUTY_LSB +: 3]
		: hw_throttle_duty_code_q;
	// only the first write lands in the thermal duty field
	assign thermal_duty_code_d = (ctrl_wr && !tduty_locked_q)
		? bus.wdata[PCT_TDUTY_LSB +: 3] : thermal_duty_code_q;
	assign tduty_locked_d = tduty_locked_q || ctrl_wr;

	// read image: reserved bits stay zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		rdata_d[PCT_STATUS_BIT] = active;
		rdata_d[PCT_FORCE_BIT] = force_q;
		rdata_d[PCT_TDUTY_LSB +: 3] = thermal_duty_code_q;
		rdata_d[PCT_HWEN_BIT] = hw_throttle_enable_q;
		rdata_d[PCT_HDUTY_LSB +: 3] = hw_throttle_duty_code_q;
	end

	// register storage, all zero at reset
	always_ff @(posedge pci_bus_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			force_q <= 1'b0;
			hw_throttle_enable_q <= 1'b0;
			hw_throttle_duty_code_q <= PCT_DUTY_ZERO;
			thermal_duty_code_q <= PCT_DUTY_ZERO;
			tduty_locked_q <= 1'b0;
			rdata_q <= PCT_CTRL_RESET;
		end
		else
		begin
			force_q <= force_d;
			hw_throttle_enable_q <= hw_throttle_enable_d;
			hw_throttle_duty_code_q <= hw_throttle_duty_code_d;
			thermal_duty_code_q <= thermal_duty_code_d;
			tduty_locked_q <= tduty_locked_d;
			rdata_q <= ctrl_rd ? rdata_d : rdata_q;
		end
	end

	// --------------------------------------------------------------
	// thermal override timer
	// --------------------------------------------------------------
	logic [31:0] therm_cnt_q, therm_cnt_d;
	logic override;

	// counts cycles of continuous alert; no enable bit can mask it
	assign override = (therm_cnt_q >= 32'(OVERRIDE_CYCLES));
	assign therm_cnt_d = thermal_alert_in_n ? 32'h0000_0000
		: (override ? therm_cnt_q : therm_cnt_q + 32'h0000_0001);

	always_ff @(posedge pci_bus_clock or negedge rst_n)
	begin
		if (!rst_n)
			therm_cnt_q <= 32'h0000_0000;
		else
			therm_cnt_q <= therm_cnt_d;
	end

	// --------------------------------------------------------------
	// throttle state and duty generator
	// --------------------------------------------------------------
	pct_state_t state_q, state_d;
	logic [9:0] phase_q;
	logic [10:0] stop_clks;
	logic [2:0] duty_sel;
	logic stop_d;

	// thermal request beats hardware; nothing outside C0
	always_comb
	begin
		if (!cpu_in_c0)
			state_d = PCT_IDLE;
		else if (override || force_q)
			state_d = PCT_THERMAL;
		else if (hw_throttle_enable_q)
			state_d = PCT_HARDWARE;
		else
			state_d = PCT_IDLE;
	end

	assign active = (state_q != PCT_IDLE);
	assign duty_sel = (state_q == PCT_THERMAL) ? thermal_duty_code_q
		: hw_throttle_duty_code_q;

	pct_duty_lut u_lut (
		.clk(pci_bus_clock),
		.rst_n(rst_n),
		.code(duty_sel),
		.stop_clks_q(stop_clks)
	);

	// one contiguous low run at the start of each period
	assign stop_d = active && ({1'b0, phase_q} < stop_clks);

	always_ff @(posedge pci_bus_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= PCT_IDLE;
			phase_q <= 10'h000;
			stop_clock_out_n <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			phase_q <= active ? phase_q + 10'h001 : 10'h000;
			stop_clock_out_n <= !stop_d;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	a_idle_no_stop: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		!cpu_in_c0 |=> ##1 stop_clock_out_n)
		else $error("stop-clock asserted outside C0");
	a_status_reflects: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		ctrl_rd |=> rdata_q[PCT_STATUS_BIT] == $past(active))
		else $error("status bit does not match throttle state");
	a_duty_locked: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		tduty_locked_q |=> $stable(thermal_duty_code_q))
		else $error("thermal duty changed after first write");
	a_reserved_zero: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		rdata_q[31:18] == 14'h0000 && rdata_q[16:9] == 8'h00)
		else $error("reserved bits nonzero");
	a_thermal_wins: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		(cpu_in_c0 && force_q) |=> state_q == PCT_THERMAL)
		else $error("forced throttle not applied");
	a_hw_start: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		(cpu_in_c0 && hw_throttle_enable_q && !force_q && !override)
		|=> state_q == PCT_HARDWARE)
		else $error("hardware throttle not started");
	a_override_on: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		(override && cpu_in_c0) |=> state_q == PCT_THERMAL)
		else $error("thermal override ignored");
	a_period_wrap: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		active |=> (!active || phase_q == $past(phase_q) + 10'h001))
		else $error("throttle phase does not step through 1024 clocks");
	a_run_start: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		(active && phase_q == 10'h000 && stop_clks != 11'h000) |=> !stop_clock_out_n)
		else $error("stop-clock not asserted at period start");
	a_half_default: assert property (@(posedge pci_bus_clock) disable iff (!rst_n)
		(duty_sel == 3'h0) |=> stop_clks == 11'h200)
		else $error("code 000 not half period");
endmodule

// ### pct_pkg.sv
// Purpose: shared constants and types for the processor clock throttle
// Assumes: 40 MHz clock, i/o register port with 8-bit address and 32-bit data
// Notes: all offsets, fields and counts live here
package pct_pkg;
	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [7:0] PCT_CTRL_OFFSET = 8'h10;
	localparam logic [31:0] PCT_CTRL_RESET = 32'h0000_0000;
	localparam int PCT_STATUS_BIT = 17;
	localparam int PCT_FORCE_BIT = 8;
	localparam int PCT_TDUTY_LSB = 5;
	localparam int PCT_HWEN_BIT = 4;
	localparam int PCT_HDUTY_LSB = 1;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int PCT_CLK_HZ = 40_000_000;
	localparam int PCT_OVERRIDE_SEC = 2;
	localparam int PCT_OVERRIDE_CYCLES = PCT_OVERRIDE_SEC * PCT_CLK_HZ;
	localparam int PCT_PERIOD_CLKS = 1024;
	localparam logic [9:0] PCT_PERIOD_LAST = 10'h3ff;
	localparam logic [2:0] PCT_DUTY_ZERO = 3'h0;
	// stop-clock cycles per 1024-clock period, per duty setting; NONE is the reset value
	localparam logic [10:0] PCT_STOP_896 = 11'h380;
	localparam logic [10:0] PCT_STOP_768 = 11'h300;
	localparam logic [10:0] PCT_STOP_640 = 11'h280;
	localparam logic [10:0] PCT_STOP_512 = 11'h200;
	localparam logic [10:0] PCT_STOP_384 = 11'h180;
	localparam logic [10:0] PCT_STOP_256 = 11'h100;
	localparam logic [10:0] PCT_STOP_128 = 11'h080;
	localparam logic [10:0] PCT_STOP_NONE = 11'h000;

	// throttle state machine
	typedef enum logic [1:0] {PCT_IDLE, PCT_THERMAL, PCT_HARDWARE} pct_state_t;

	// register access strobe group
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pct_bus_t;
endpackage

// ### pct_duty_lut.sv
// Purpose: maps a 3-bit duty code to stop-clock cycles per period
// Assumes: one 1024-clock period
// Notes: registered output, one clock of latency
`timescale 1ns/1ps
module pct_duty_lut
	import pct_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// code in, count out
	input wire logic [2:0] code,
	output logic [10:0] stop_clks_q
);
	logic [10:0] stop_clks_d;

	// 000 is reserved and behaves as half of the period
	always_comb
	begin
		unique case (code)
			3'h0: stop_clks_d = PCT_STOP_512;
			3'h1: stop_clks_d = PCT_STOP_896;
			3'h2: stop_clks_d = PCT_STOP_768;
			3'h3: stop_clks_d = PCT_STOP_640;
			3'h4: stop_clks_d = PCT_STOP_512;
			3'h5: stop_clks_d = PCT_STOP_384;
			3'h6: stop_clks_d = PCT_STOP_256;
			3'h7: stop_clks_d = PCT_STOP_128;
		endcase
	end

	// result register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stop_clks_q <= PCT_STOP_NONE;
		else
			stop_clks_q <= stop_clks_d;
	end
endmodule

// ### pct_cpu_model.sv
// Purpose: processor side of stop-clock, measures each throttle period
// Assumes: stop_clock_out_n is registered on the same clock
// Notes: first report after a start or code change is partial
`timescale 1ns/1ps
module pct_cpu_model
(
	// clock and pin
	input wire logic clk,
	input wire logic stop_clock_out_n,
	// last full period seen
	output logic [10:0] lo_len,
	output logic [10:0] per_len,
	output logic per_done
);
	logic [10:0] lo_q = '0;
	logic [10:0] hi_q = '0;
	logic prev_q = 1'b1;
	// each falling edge closes one low run plus the high gap after it
	always_ff @(posedge clk)
	begin
		per_done <= 1'b0;
		prev_q <= stop_clock_out_n;
		if (!stop_clock_out_n && prev_q)
		begin
			lo_len <= lo_q;
			per_len <= lo_q + hi_q;
			per_done <= 1'b1;
			lo_q <= 11'h001;
			hi_q <= '0;
		end
		else if (!stop_clock_out_n)
			lo_q <= lo_q + 11'h001;
		else
			hi_q <= hi_q + 11'h001;
	end
endmodule

// ### processor_clock_throttle_tb.sv
// Purpose: self-checking bench for the clock throttle
// Assumes: override shortened to 20 clocks
// Notes: duty is judged on the third period after each change
`timescale 1ns/1ps
module processor_clock_throttle_tb;
	import pct_pkg::*;
	logic clk, rst_n, c0, alert_n, stop_n, per_done;
	pct_bus_t bus;
	logic [31:0] rdata, v;
	logic [10:0] lo_len, per_len;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	int dty [8] = '{512, 896, 768, 640, 512, 384, 256, 128};
	// ------------------------------------------------------------
	// design and processor model
	// ------------------------------------------------------------
	pct_throttle #(.OVERRIDE_CYCLES(20)) u_pct_throttle (.pci_bus_clock(clk),
		.reset_n(rst_n), .bus(bus), .rdata_q(rdata), .cpu_in_c0(c0),
		.thermal_alert_in_n(alert_n), .stop_clock_out_n(stop_n));
	pct_cpu_model u_pct_cpu_model (.clk(clk), .stop_clock_out_n(stop_n),
		.lo_len(lo_len), .per_len(per_len), .per_done(per_done));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 70000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task do_reset();
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	// one strobe cycle, inputs move on the falling edge
	task access(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		bus = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		bus = '0;
		v = rdata;
	endtask
	task period(input int n);
		int c;
		c = 0;
		for (int i = 0; i < 3400 && c < 3; i++)
		begin
			@(negedge clk);
			if (per_done)
				c++;
		end
		check(c, 3);
		check({21'h0, lo_len}, n);
		check({21'h0, per_len}, 32'h400);
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		bus = '0;
		c0 = 1'b1;
		alert_n = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			do_reset();
			access(1'b0, 8'h10, 32'h0);
			check(v, 32'h0);
			access(1'b1, 8'h10, 32'h100 | (k << 5));
			period(dty[k]);
			access(1'b0, 8'h10, 32'h0);
			check(v, 32'h20100 | (k << 5));
		end
		$display("test thermal codes done");
		access(1'b1, 8'h10, 32'h120);
		period(128);
		access(1'b0, 8'h14, 32'h0);
		check(v, 32'h201e0);
		c0 = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 1100; i++)
		begin
			@(negedge clk);
			check(stop_n, 32'h1);
		end
		access(1'b0, 8'h10, 32'h0);
		check(v, 32'h1e0);
		c0 = 1'b1;
		$display("test write once and c2 done");
		do_reset();
		for (int h = 0; h < 8; h++)
		begin
			access(1'b1, 8'h10, 32'h10 | (h << 1));
			period(dty[h]);
		end
		alert_n = 1'b0;
		period(512);
		access(1'b0, 8'h10, 32'h0);
		check(v, 32'h2001e);
		$display("test hardware and override done");
		tally_and_finish();
	end
endmodule
